//--- rtl/flash_cfg_defines.svh
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH
`define FC_ADDR_STATUS 4'h0
`define FC_ADDR_CONFIG 4'h1
`define FC_ADDR_SECURITY 4'h2
`define FC_ADDR_EVENTS 4'h3
`define FC_ADDR_MASK 4'h4
`define FC_BIT_DONE 7
`define FC_BIT_COLL 6
`define FC_BIT_ERSA 5
`define FC_BIT_SUSP 4
`define FC_CONFIG_RESET 8'h00
`define FC_EV_DONE 0
`define FC_EV_COLL 1
`define FC_EV_ERSA 2
`define FC_SEC_UNSECURE 2'h2
`define FC_STEP_CYCLES 16'h0010
`endif

//--- rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_VERIFY,
    ST_PROGRAM,
    ST_UNSECURE
  } erase_all_state_t;
endpackage : flash_cfg_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else if (i_ce) begin
      stage1_ff <= i_async;
      stage2_ff <= stage1_ff;
    end
  end
  assign o_sync = stage2_ff;
endmodule : pin_sync
`default_nettype wire

//--- rtl/flash_config_control.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "flash_cfg_defines.svh"
module flash_config_control
  import flash_cfg_pkg::*;
#(
  parameter logic [15:0] STEP_CYCLES = `FC_STEP_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_erase_all_req,
  input wire logic i_cmd_done,
  input wire logic i_read_clash,
  output logic o_cmd_launch,
  output logic o_erase_suspend,
  output logic o_irq,
  output logic o_flash_irq,
  output logic [1:0] o_security
);
  logic [2:0] pin_s;
  logic ersa_pin_s;
  logic done_pin_s;
  logic clash_pin_s;
  logic ersa_pin_d_ff;
  logic done_flag_ff;
  logic coll_flag_ff;
  logic done_irq_enable_ff;
  logic collision_irq_enable_ff;
  logic erase_all_request_ff;
  logic erase_suspend_ff;
  logic [1:0] sec_ff;
  logic [2:0] events_ff;
  logic [2:0] mask_ff;
  logic launch_ff;
  logic flash_irq_ff;
  logic irq_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [15:0] step_cnt_ff;
  erase_all_state_t state_ff;
  erase_all_state_t nxt_state;
  logic step_done;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic ersa_start;
  logic ersa_finish;
  logic done_rise;
  logic coll_rise;

  pin_sync #(.WIDTH(3)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_erase_all_req, i_cmd_done, i_read_clash}),
    .o_sync(pin_s)
  );
  assign ersa_pin_s = pin_s[2];
  assign done_pin_s = pin_s[1];
  assign clash_pin_s = pin_s[0];

  // One wait cycle per access keeps read data registered
  // Writes commit only at the edge that sees waitrequest low
  assign wr_acc = i_write && ack_ff;
  assign rd_acc = i_read && !ack_ff;
  assign wbyte = i_writedata[7:0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
      o_waitrequest <= 1'b1;
    end else if (i_ce) begin
      ack_ff <= (i_read || i_write) && !ack_ff;
      o_waitrequest <= !((i_read || i_write) && !ack_ff);
    end
  end

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] target);
    is_addr = (a == target);
  endfunction : is_addr

  // Start only on a request edge while no command runs
  assign ersa_start = ersa_pin_s && !ersa_pin_d_ff && done_flag_ff &&
                      (state_ff == ST_IDLE);
  assign step_done = (step_cnt_ff == STEP_CYCLES - 16'h0001);
  assign ersa_finish = (state_ff == ST_UNSECURE) && step_done;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ersa_start) begin
          nxt_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (step_done) begin
          nxt_state = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (step_done) begin
          nxt_state = ST_PROGRAM;
        end
      end
      ST_PROGRAM: begin
        if (step_done) begin
          nxt_state = ST_UNSECURE;
        end
      end
      ST_UNSECURE: begin
        if (step_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      step_cnt_ff <= 16'h0000;
      ersa_pin_d_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      ersa_pin_d_ff <= ersa_pin_s;
      if (state_ff == ST_IDLE || step_done) begin
        step_cnt_ff <= 16'h0000;
      end else begin
        step_cnt_ff <= step_cnt_ff + 16'h0001;
      end
    end
  end

  // Hardware-only bit; software writes never reach it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      erase_all_request_ff <= 1'b0;
    end else if (i_ce) begin
      if (ersa_start) begin
        erase_all_request_ff <= 1'b1;
      end else if (ersa_finish) begin
        erase_all_request_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sec_ff <= 2'h0;
    end else if (i_ce && ersa_finish) begin
      sec_ff <= `FC_SEC_UNSECURE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      done_irq_enable_ff <= 1'b0;
      collision_irq_enable_ff <= 1'b0;
      erase_suspend_ff <= 1'b0;
    end else if (i_ce && wr_acc && is_addr(i_address, `FC_ADDR_CONFIG)) begin
      done_irq_enable_ff <= wbyte[`FC_BIT_DONE];
      collision_irq_enable_ff <= wbyte[`FC_BIT_COLL];
      erase_suspend_ff <= wbyte[`FC_BIT_SUSP];
    end
  end

  // Done flag: launch write clears, completion sets; erase-all also busies it
  assign done_rise = done_pin_s || ersa_finish;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      done_flag_ff <= 1'b1;
      launch_ff <= 1'b0;
    end else if (i_ce) begin
      launch_ff <= 1'b0;
      if (ersa_start) begin
        done_flag_ff <= 1'b0;
      end else if (wr_acc && is_addr(i_address, `FC_ADDR_STATUS) &&
                   wbyte[`FC_BIT_DONE] && done_flag_ff && state_ff == ST_IDLE) begin
        done_flag_ff <= 1'b0;
        launch_ff <= 1'b1;
      end else if (!done_flag_ff && done_rise && !launch_ff) begin
        done_flag_ff <= 1'b1;
      end
    end
  end

  // Detection wins over a same-cycle write-1 clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      coll_flag_ff <= 1'b0;
    end else if (i_ce) begin
      if (clash_pin_s && !done_flag_ff) begin
        coll_flag_ff <= 1'b1;
      end else if (wr_acc && is_addr(i_address, `FC_ADDR_STATUS) && wbyte[`FC_BIT_COLL]) begin
        coll_flag_ff <= 1'b0;
      end
    end
  end

  assign coll_rise = clash_pin_s && !done_flag_ff && !coll_flag_ff;

  // Sticky events, cleared by reading; a new event wins over the read
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      events_ff <= 3'h0;
      mask_ff <= 3'h0;
    end else if (i_ce) begin
      if (rd_acc && is_addr(i_address, `FC_ADDR_EVENTS)) begin
        events_ff <= 3'h0;
      end
      if (!done_flag_ff && done_rise && !launch_ff) begin
        events_ff[`FC_EV_DONE] <= 1'b1;
      end
      if (coll_rise) begin
        events_ff[`FC_EV_COLL] <= 1'b1;
      end
      if (ersa_finish) begin
        events_ff[`FC_EV_ERSA] <= 1'b1;
      end
      if (wr_acc && is_addr(i_address, `FC_ADDR_MASK)) begin
        mask_ff <= i_writedata[2:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flash_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (i_ce) begin
      flash_irq_ff <= (done_irq_enable_ff && done_flag_ff) ||
                      (collision_irq_enable_ff && coll_flag_ff);
      irq_ff <= |(events_ff & mask_ff);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_ce && rd_acc) begin
      if (is_addr(i_address, `FC_ADDR_STATUS)) begin
        rdata_ff <= {24'h00_0000, done_flag_ff, coll_flag_ff, 6'h00};
      end else if (is_addr(i_address, `FC_ADDR_CONFIG)) begin
        rdata_ff <= {24'h00_0000, done_irq_enable_ff, collision_irq_enable_ff,
                     erase_all_request_ff, erase_suspend_ff, 4'h0};
      end else if (is_addr(i_address, `FC_ADDR_SECURITY)) begin
        rdata_ff <= {30'h0000_0000, sec_ff};
      end else if (is_addr(i_address, `FC_ADDR_EVENTS)) begin
        rdata_ff <= {29'h0000_0000, events_ff};
      end else if (is_addr(i_address, `FC_ADDR_MASK)) begin
        rdata_ff <= {29'h0000_0000, mask_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign o_readdata = rdata_ff;
  assign o_cmd_launch = launch_ff;
  assign o_erase_suspend = erase_suspend_ff;
  assign o_irq = irq_ff;
  assign o_flash_irq = flash_irq_ff;
  assign o_security = sec_ff;
endmodule : flash_config_control
`default_nettype wire

//--- bench/flash_config_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module flash_config_control_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_cmd_launch,
  input wire logic o_erase_suspend,
  input wire logic [1:0] o_security
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_ack;
    !o_waitrequest && i_ce;
  endsequence
  sequence s_wcfg;
    i_write && i_address == 4'h1 ##0 s_ack;
  endsequence
  sequence s_rcfg;
    i_read && i_address == 4'h1 ##0 s_ack;
  endsequence
  property p_ack; s_ack |=> o_waitrequest; endproperty
  property p_answer; (i_read || i_write) && o_waitrequest |-> ##[1:2] !o_waitrequest; endproperty
  property p_low_zero; s_rcfg |-> o_readdata[3:0] == 4'h0 && o_readdata[31:8] == 24'h0; endproperty
  property p_unmapped; i_read && i_address > 4'h4 ##0 s_ack |-> o_readdata == 32'h0; endproperty
  property p_susp; s_wcfg |=> o_erase_suspend == $past(i_writedata[4]); endproperty
  property p_susp_rd; s_rcfg |-> o_readdata[4] == o_erase_suspend; endproperty
  property p_sec; $changed(o_security) |-> o_security == 2'h2; endproperty
  property p_ersa; s_rcfg ##0 o_readdata[5] |-> $past(o_security) == 2'h0; endproperty
  property p_launch; o_cmd_launch |=> !o_cmd_launch; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than a cycle");
  a_answer: assert property (p_answer) else $error("no ack");
  a_low_zero: assert property (p_low_zero) else $error("config low bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_susp: assert property (p_susp) else $error("suspend not written");
  a_susp_rd: assert property (p_susp_rd) else $error("suspend readback");
  a_sec: assert property (p_sec) else $error("bad security change");
  a_ersa: assert property (p_ersa) else $error("unsecure before done");
  a_launch: assert property (p_launch) else $error("launch too long");
endmodule : flash_config_control_asserts
bind flash_config_control flash_config_control_asserts u_chk (.i_ref_clk, .i_rst, .i_ce,
  .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .o_cmd_launch,
  .o_erase_suspend, .o_security);
`default_nettype wire

//--- bench/test_flash_config_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_flash_config_control;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] address = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic ersa_req = 1'b0;
  logic cmd_done = 1'b0;
  logic clash = 1'b0;
  logic [31:0] rdata;
  logic waitreq, launch, susp, irq, flash_irq;
  logic [1:0] security;
  logic launched = 1'b0;
  logic [7:0] q, d;
  int fails = 0;
  int checks_done = 0;
  int seed = 32'h933c7946;
  int n;
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) launched <= launched | launch;
  // Short steps keep the erase-all run brief
  flash_config_control #(.STEP_CYCLES(16'h0008)) DUT (.i_ref_clk(ref_clk), .i_rst(rst),
    .i_ce(ce), .i_address(address), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .o_readdata(rdata), .o_waitrequest(waitreq), .i_erase_all_req(ersa_req),
    .i_cmd_done(cmd_done), .i_read_clash(clash), .o_cmd_launch(launch),
    .o_erase_suspend(susp), .o_irq(irq), .o_flash_irq(flash_irq), .o_security(security));
  task conclude;
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  // Waitrequest and read data are read just after the edge, before they update
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    int t;
    t = 0;
    rd <= !w;
    wr <= w;
    address <= a;
    wdata <= {24'h0, v};
    do begin
      @(posedge ref_clk);
      t++;
    end while (waitreq !== 1'b0 && t < 20);
    if (waitreq !== 1'b0) begin
      fails++;
      conclude();
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  // Held three cycles so the synchronisers catch it
  task pulse(input logic [1:0] k);
    {clash, cmd_done} <= k;
    tick(3);
    {clash, cmd_done} <= 2'b00;
    tick(5);
  endtask : pulse
  initial begin
    tick(8);
    rst <= 1'b0;
    bus(0, 4'h1, 0);
    chk("cfg reset", q, 8'h00);
    chk("sec reset", security, 2'h0);
    bus(0, 4'h0, 0);
    chk("done flag", q[7], 1'b1);
    bus(0, 4'hf, 0);
    chk("unmapped", q, 8'h00);
    bus(0, 4'h3, 0);
    repeat (16) begin
      d = 8'($random(seed));
      bus(1, 4'h1, d);
      bus(0, 4'h1, 0);
      chk("cfg", q, {d[7:6], 1'b0, d[4], 4'h0});
      chk("suspend", susp, d[4]);
      chk("done irq", flash_irq, d[7]);
    end
    bus(1, 4'h4, 8'h01);
    bus(1, 4'h1, 8'h80);
    bus(1, 4'h0, 8'h80);
    bus(0, 4'h0, 0);
    chk("busy", q[7], 1'b0);
    chk("launch", launched, 1'b1);
    chk("done irq off", flash_irq, 1'b0);
    ersa_req <= 1'b1;
    pulse(2'b10);
    bus(0, 4'h0, 0);
    chk("clash", q[6], 1'b1);
    bus(0, 4'h1, 0);
    chk("ersa blocked", q[5], 1'b0);
    bus(1, 4'h1, 8'h40);
    tick(2);
    chk("coll irq", flash_irq, 1'b1);
    chk("masked", irq, 1'b0);
    bus(1, 4'h0, 8'h00);
    bus(0, 4'h0, 0);
    chk("w0 keeps", q[6], 1'b1);
    bus(1, 4'h0, 8'h40);
    bus(0, 4'h0, 0);
    chk("w1 clears", q[6], 1'b0);
    chk("coll irq off", flash_irq, 1'b0);
    ersa_req <= 1'b0;
    bus(1, 4'h1, 8'h80);
    // Completion while frozen must be lost
    ce <= 1'b0;
    pulse(2'b01);
    ce <= 1'b1;
    bus(0, 4'h0, 0);
    chk("frozen", q[7], 1'b0);
    chk("frozen irq", flash_irq, 1'b0);
    pulse(2'b01);
    chk("done irq on", flash_irq, 1'b1);
    chk("event irq", irq, 1'b1);
    bus(0, 4'h3, 0);
    chk("events", q, 8'h03);
    tick(2);
    chk("event irq off", irq, 1'b0);
    bus(1, 4'h4, 8'h04);
    ersa_req <= 1'b1;
    tick(4);
    bus(1, 4'h1, 8'h00);
    bus(0, 4'h1, 0);
    chk("ersa set", q[5], 1'b1);
    for (n = 0; n < 200 && security !== 2'h2; n++) tick(1);
    chk("unsecure", security, 2'h2);
    tick(2);
    chk("ersa irq", irq, 1'b1);
    bus(0, 4'h2, 0);
    chk("sec reg", q, 8'h02);
    bus(0, 4'h1, 0);
    chk("ersa clear", q[5], 1'b0);
    bus(0, 4'h0, 0);
    chk("done again", q[7], 1'b1);
    bus(0, 4'h3, 0);
    chk("ersa event", q[2], 1'b1);
    conclude();
  end
endmodule : test_flash_config_control
`default_nettype wire
